/* File: dv/fpf_core_tb.sv */
// self-checking bench of the fan pwm core
`timescale 1ns/100ps
module fpf_core_tb;
   `define CHK(g, e) check(32'(g), 32'(e))
   logic                core_clk = 1'b0;
   logic                rst_b    = 1'b0;
   logic                hsel     = 1'b0;
   logic [31:0]         haddr    = 32'h0;
   logic [1:0]          htrans   = 2'b00;
   logic                hwrite   = 1'b0;
   logic [31:0]         hwdata   = 32'h0;
   logic [31:0]         hrdata;
   logic                hreadyout, hresp, pwm_drive, alarm_b, alarm_oe, irq, tach;
   logic                ot = 1'b0, vo = 1'b1, stall = 1'b0;
   logic [3:0]          tc = 4'h0;
   logic [7:0]          half = 8'h19;
   fpf_pkg::fpf_sense_t sense;
   int                  errors = 0, comparisons = 0, cyc = 0;
   assign sense = '{tach: tach, overtemp: ot, vin_open: vo, temp_code: tc};
   always #2.5 core_clk = ~core_clk;
   fpf_core #(.STARTUP_CYC(200), .MEAS_CYC(500), .SLOT_CYC(2)) dut_u (
      .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sense_in(sense), .pwm_drive(pwm_drive),
      .alarm_b(alarm_b), .alarm_oe(alarm_oe), .irq(irq));
   fpf_fan_model fan_u (.core_clk(core_clk), .half_cyc(half), .stall(stall), .tach(tach));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic finish_test();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge core_clk);
      hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      `CHK(hresp, 0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      `CHK(x, e);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic count_hi(input int n, output int h);
      h = 0;
      repeat (n) begin
         @(posedge core_clk);
         h += (pwm_drive === 1'b1);
      end
   endtask
   function automatic int hi(input int code);
      return (90 + 14 * code) * 2;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_startup();
      int h;
      wait_cyc(2);
      `CHK(alarm_b, 0);
      count_hi(190, h);
      `CHK(h, 190);
      wait_cyc(610);
      count_hi(600, h);
      `CHK(h, hi(2));
   endtask
   task automatic t_regs();
      rd_chk(fpf_pkg::OFS_CTRL, 0);
      rd_chk(fpf_pkg::OFS_DUTY, 0);
      rd_chk(fpf_pkg::OFS_THRESH, 32'h1f4);
      rd_chk(fpf_pkg::OFS_IRQ_EN, 0);
      rd_chk(8'h40, 0);
      wr(fpf_pkg::OFS_STATUS, 32'hffff_ffff);
      rd_chk(fpf_pkg::OFS_IRQ_CLR, 0);
   endtask
   task automatic t_duty_reg();
      int h;
      wr(fpf_pkg::OFS_CTRL, 32'h20);
      for (int c = 0; c < 16; c++) begin
         wr(fpf_pkg::OFS_DUTY, c);
         rd_chk(fpf_pkg::OFS_DUTY, c);
         wait_cyc(600);
         count_hi(600, h);
         `CHK(h, hi(c));
      end
   endtask
   task automatic t_analog();
      int h;
      wr(fpf_pkg::OFS_CTRL, 32'h0);
      vo <= 1'b0;
      tc <= 4'h5;
      wait_cyc(610);
      count_hi(600, h);
      `CHK(h, hi(5));
   endtask
   task automatic t_tach();
      logic [31:0] r;
      int          h;
      wr(fpf_pkg::OFS_THRESH, 32'hc8);
      wait_cyc(1100);
      bus(1'b0, fpf_pkg::OFS_RPM, 0, r);
      `CHK(r >= 270 && r <= 330, 1);
      `CHK(alarm_b, 1);
      half <= 8'h32;
      wait_cyc(1100);
      bus(1'b0, fpf_pkg::OFS_RPM, 0, r);
      `CHK(r >= 120 && r <= 180, 1);
      `CHK(alarm_b, 0);
      `CHK(alarm_oe, 1);
      stall <= 1'b1;
      wait_cyc(1100);
      rd_chk(fpf_pkg::OFS_RPM, 0);
      rd_chk(fpf_pkg::OFS_STATUS, 1);
      count_hi(600, h);
      `CHK(h, hi(5));
      stall <= 1'b0;
      half  <= 8'h19;
      wait_cyc(1100);
   endtask
   task automatic t_overtemp();
      ot <= 1'b1;
      wait_cyc(8);
      `CHK(irq, 0);
      rd_chk(fpf_pkg::OFS_STATUS, 32'h21);
      `CHK(alarm_b, 1);
      wr(fpf_pkg::OFS_CTRL, 32'h22);
      wait_cyc(4);
      `CHK(alarm_b, 0);
      wr(fpf_pkg::OFS_IRQ_EN, 32'h20);
      wait_cyc(4);
      `CHK(irq, 1);
      ot <= 1'b0;
      wait_cyc(8);
      `CHK(alarm_b, 1);
      `CHK(irq, 1);
      wr(fpf_pkg::OFS_IRQ_CLR, 32'h21);
      wait_cyc(4);
      `CHK(irq, 0);
      rd_chk(fpf_pkg::OFS_STATUS, 0);
   endtask
   task automatic t_shutdown();
      int h;
      wr(fpf_pkg::OFS_DUTY, 3);
      wr(fpf_pkg::OFS_CTRL, 32'h21);
      wait_cyc(4);
      count_hi(600, h);
      `CHK(h, 0);
      wr(fpf_pkg::OFS_CTRL, 32'h20);
      wait_cyc(2);
      count_hi(190, h);
      `CHK(h, 190);
      wait_cyc(610);
      count_hi(600, h);
      `CHK(h, hi(3));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      t_startup();
      t_regs();
      t_duty_reg();
      t_analog();
      t_tach();
      t_overtemp();
      t_shutdown();
      finish_test();
   end
endmodule // fpf_core_tb

/* File: dv/fpf_fan_model.sv */
// behavioural brushless fan: tach pulses at a set rate, or none when stalled
`timescale 1ns/100ps
module fpf_fan_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] half_cyc,
   input  wire logic       stall,
   output logic            tach
);
   logic [7:0] cnt    = 8'h00;
   logic       tach_q = 1'b0;
   assign tach = tach_q;
   // two tach pulses per revolution; a locked rotor leaves the line low
   always @(posedge core_clk) begin
      if (stall) begin
         cnt    <= 8'h00;
         tach_q <= 1'b0;
      end else if (cnt >= half_cyc - 8'h01) begin
         cnt    <= 8'h00;
         tach_q <= ~tach_q;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule // fpf_fan_model

/* File: hw/fpf_core.sv */
// fan pwm drive with startup boost, tach rpm, fault alarm and ahb-lite registers
//
// Function
// RULE_01: the alarm output goes low while measured rpm is below the speed threshold.
// RULE_02: tach pulses are counted each window and turned into rpm.
// RULE_03: the over-temperature input sets status bit 5.
// RULE_04: with the over-temperature alarm variant enabled, alarm stays low during it.
// RULE_05: the drive output is active high, high turns the fan on.
// RULE_06: fixed period, only the high time varies, between 30% and 100%.
// RULE_07: at full code the drive stays high for the whole period.
// RULE_08: nominal 30 Hz, settable 15 to 35 Hz, period scales with the parameter.
// RULE_09: after reset or leaving shutdown the drive is full on for one second.
// RULE_10: after startup the duty source bit picks analog code or duty register.
// RULE_11: analog source by default, an open analog input gives 39.33%.
// RULE_12: software sets the duty source bit first, then writes the duty register.
// RULE_13: the duty register is 4 bits read/write, 0 is 30%, 15 is 100%.
// RULE_14: drive stops only in shutdown, it keeps pulsing whatever the rpm.
// RULE_15: analog results arrive as digital inputs, the one second is a cycle count.
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module fpf_core #(
   parameter int STARTUP_CYC = fpf_pkg::STARTUP_CYC,
   parameter int MEAS_CYC    = fpf_pkg::MEAS_CYC,
   parameter int PWM_HZ      = fpf_pkg::PWM_HZ_NOM,
   parameter int SLOT_CYC    = fpf_pkg::CLK_HZ / (PWM_HZ * fpf_pkg::PWM_SLOTS)
) (
   input  wire logic               core_clk,
   input  wire logic               rst_b,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic [31:0]             hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   input  wire fpf_pkg::fpf_sense_t sense_in,
   output logic                    pwm_drive,
   output logic                    alarm_b,
   output logic                    alarm_oe,
   output logic                    irq
);

   localparam logic [27:0] START_LAST = 28'(STARTUP_CYC - 1);
   localparam logic [15:0] PRE_LAST   = 16'(SLOT_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // input synchroniser

   fpf_pkg::fpf_sense_t sense_m;
   fpf_pkg::fpf_sense_t sense_s;

   always_ff @(posedge core_clk) begin // RULE_15
      if (!rst_b) begin
         sense_m <= '0;
         sense_s <= '0;
      end else begin
         sense_m <= sense_in;
         sense_s <= sense_m;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // tach measurement

   logic [15:0] rpm;

   fpf_tach #(
      .MEAS_CYC (MEAS_CYC)
   ) u_tach (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .tach_s   (sense_s.tach),
      .rpm      (rpm)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // register file and bus slave

   fpf_pkg::fpf_ctrl_t ctrl;
   logic [3:0]         duty_reg;
   logic [15:0]        thresh;
   logic [5:0]         status;
   logic [5:0]         irq_en;
   logic               wr_pend;
   logic [7:0]         wr_addr;
   fpf_pkg::fpf_ctrl_t next_ctrl;
   logic [3:0]         next_duty_reg;
   logic [15:0]        next_thresh;
   logic [5:0]         next_status;
   logic [5:0]         next_irq_en;
   logic               next_wr_pend;
   logic [7:0]         next_wr_addr;
   logic [31:0]        next_hrdata;
   logic               next_irq;
   logic [5:0]         set_mask;
   logic [5:0]         clr_mask;
   logic               addr_ok;
   logic               fan_low;

   always_comb begin
      addr_ok       = hsel & htrans[1] & hready;
      fan_low       = rpm < thresh;
      next_ctrl     = ctrl;
      next_duty_reg = duty_reg;
      next_thresh   = thresh;
      next_irq_en   = irq_en;
      next_wr_pend  = addr_ok & hwrite;
      next_wr_addr  = haddr[7:0];
      next_hrdata   = 32'h00000000;
      set_mask      = 6'h00;
      clr_mask      = 6'h00;
      set_mask[fpf_pkg::ST_FAN_BIT] = fan_low;
      set_mask[fpf_pkg::ST_OT_BIT]  = sense_s.overtemp; // RULE_03
      if (wr_pend) begin
         case (wr_addr)
            fpf_pkg::OFS_CTRL: begin
               next_ctrl.shutdown_request   = hwdata[fpf_pkg::CTRL_SHUTDOWN_BIT];
               next_ctrl.ot_alarm_en        = hwdata[fpf_pkg::CTRL_OT_ALARM_BIT];
               next_ctrl.duty_source_select = hwdata[fpf_pkg::CTRL_DUTY_SRC_BIT];
            end
            fpf_pkg::OFS_DUTY:    next_duty_reg = hwdata[3:0]; // RULE_13
            fpf_pkg::OFS_THRESH:  next_thresh   = hwdata[15:0];
            fpf_pkg::OFS_IRQ_EN:  next_irq_en   = hwdata[5:0];
            fpf_pkg::OFS_IRQ_CLR: clr_mask      = hwdata[5:0];
            default: ;
         endcase
      end
      // a set in the clearing cycle survives
      next_status = (status & ~clr_mask) | set_mask;
      next_irq    = |(next_status & next_irq_en);
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            fpf_pkg::OFS_CTRL: begin
               next_hrdata[fpf_pkg::CTRL_SHUTDOWN_BIT] = ctrl.shutdown_request;
               next_hrdata[fpf_pkg::CTRL_OT_ALARM_BIT] = ctrl.ot_alarm_en;
               next_hrdata[fpf_pkg::CTRL_DUTY_SRC_BIT] = ctrl.duty_source_select;
            end
            fpf_pkg::OFS_DUTY:   next_hrdata = {28'h0000000, duty_reg};
            fpf_pkg::OFS_THRESH: next_hrdata = {16'h0000, thresh};
            fpf_pkg::OFS_RPM:    next_hrdata = {16'h0000, rpm}; // RULE_02
            fpf_pkg::OFS_STATUS: next_hrdata = {26'h0000000, status};
            fpf_pkg::OFS_IRQ_EN: next_hrdata = {26'h0000000, irq_en};
            default:             next_hrdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ctrl      <= '0; // RULE_11
         duty_reg  <= fpf_pkg::DUTY_RESET;
         thresh    <= fpf_pkg::THRESH_RESET;
         status    <= 6'h00;
         irq_en    <= 6'h00;
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         hrdata    <= 32'h00000000;
         irq       <= 1'b0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         duty_reg  <= next_duty_reg;
         thresh    <= next_thresh;
         status    <= next_status;
         irq_en    <= next_irq_en;
         wr_pend   <= next_wr_pend;
         wr_addr   <= next_wr_addr;
         hrdata    <= next_hrdata;
         irq       <= next_irq;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // startup sequence and pwm generator

   fpf_pkg::fpf_state_t state;
   fpf_pkg::fpf_state_t next_state;
   logic [27:0]         start_cnt;
   logic [15:0]         pre_cnt;
   logic [8:0]          slot_cnt;
   logic [27:0]         next_start_cnt;
   logic [15:0]         next_pre_cnt;
   logic [8:0]          next_slot_cnt;
   logic                next_pwm;
   logic                next_alarm_b;
   logic [3:0]          duty_code;
   logic [8:0]          high_slots;
   logic                slot_tick;

   always_comb begin
      next_state     = state;
      next_start_cnt = start_cnt;
      case (state)
         fpf_pkg::ST_START: begin // RULE_09
            next_start_cnt = start_cnt + 28'h0000001;
            if (ctrl.shutdown_request) begin
               next_state = fpf_pkg::ST_SHUT;
            end else if (start_cnt == START_LAST) begin
               next_state = fpf_pkg::ST_RUN;
            end
         end
         fpf_pkg::ST_RUN: begin
            if (ctrl.shutdown_request) begin // RULE_14
               next_state = fpf_pkg::ST_SHUT;
            end
         end
         fpf_pkg::ST_SHUT: begin
            next_start_cnt = 28'h0000000;
            if (!ctrl.shutdown_request) begin
               next_state = fpf_pkg::ST_START;
            end
         end
         default: begin
            next_state     = fpf_pkg::ST_START;
            next_start_cnt = 28'h0000000;
         end
      endcase
      // slot divider keeps the period fixed
      slot_tick     = pre_cnt == PRE_LAST; // RULE_08
      next_pre_cnt  = slot_tick ? 16'h0000 : pre_cnt + 16'h0001;
      next_slot_cnt = slot_cnt;
      if (slot_tick) begin
         next_slot_cnt = (slot_cnt == fpf_pkg::SLOT_LAST) ? 9'h000 : slot_cnt + 9'h001; // RULE_06
      end
      if (ctrl.duty_source_select) begin // RULE_10
         duty_code = duty_reg;
      end else if (sense_s.vin_open) begin // RULE_11
         duty_code = fpf_pkg::DUTY_OPEN;
      end else begin
         duty_code = sense_s.temp_code;
      end
      // code 15 gives all 300 slots high
      high_slots = fpf_pkg::DUTY_BASE + 9'(fpf_pkg::DUTY_STEP * {5'h00, duty_code}); // RULE_07
      case (state)
         fpf_pkg::ST_START: next_pwm = 1'b1;
         fpf_pkg::ST_RUN:   next_pwm = slot_cnt < high_slots; // RULE_05
         default:           next_pwm = 1'b0; // RULE_14
      endcase
      next_alarm_b = ~(fan_low | (sense_s.overtemp & ctrl.ot_alarm_en)); // RULE_01 RULE_04
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state     <= fpf_pkg::ST_START;
         start_cnt <= 28'h0000000;
         pre_cnt   <= 16'h0000;
         slot_cnt  <= 9'h000;
         pwm_drive <= 1'b0;
         alarm_b   <= 1'b1;
         alarm_oe  <= 1'b0;
      end else begin
         state     <= next_state;
         start_cnt <= next_start_cnt;
         pre_cnt   <= next_pre_cnt;
         slot_cnt  <= next_slot_cnt;
         pwm_drive <= next_pwm;
         alarm_b   <= next_alarm_b;
         alarm_oe  <= ~next_alarm_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   startup_full_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_09
      state == fpf_pkg::ST_START && $past(state) == fpf_pkg::ST_START && $past(rst_b)
         |-> pwm_drive)
      else $error("drive not full during startup");

   startup_len_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_15
      $rose(state == fpf_pkg::ST_RUN) |-> $past(start_cnt) == START_LAST)
      else $error("startup interval has wrong length");

   shutdown_off_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_14
      state == fpf_pkg::ST_SHUT && $past(state) == fpf_pkg::ST_SHUT |-> !pwm_drive)
      else $error("drive active in shutdown");

   full_duty_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_07
      (state == fpf_pkg::ST_RUN && duty_code == fpf_pkg::DUTY_FULL) [*2] |-> pwm_drive)
      else $error("full duty shows a low interval");

   min_high_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_06
      $fell(pwm_drive) && $past(state) == fpf_pkg::ST_RUN |-> $past(slot_cnt) >= fpf_pkg::DUTY_BASE)
      else $error("high time below minimum duty");

   slot_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_08
      slot_tick && slot_cnt == fpf_pkg::SLOT_LAST |=> slot_cnt == 9'h000)
      else $error("pwm period does not wrap");

   open_default_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_11
      !ctrl.duty_source_select && sense_s.vin_open |-> duty_code == fpf_pkg::DUTY_OPEN)
      else $error("open analog input not at default duty");

   reg_source_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_10
      ctrl.duty_source_select |-> duty_code == duty_reg)
      else $error("duty register not governing duty");

   fan_alarm_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_01
      rpm < thresh |=> !alarm_b && alarm_oe)
      else $error("alarm not asserted on low rpm");

   ot_alarm_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_04
      sense_s.overtemp && ctrl.ot_alarm_en |=> !alarm_b)
      else $error("alarm not asserted on over-temperature");

   ot_flag_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_03
      sense_s.overtemp |=> status[fpf_pkg::ST_OT_BIT])
      else $error("over-temperature flag not set");

   ot_flag_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_03
      status[fpf_pkg::ST_OT_BIT] && !clr_mask[fpf_pkg::ST_OT_BIT] |=> status[fpf_pkg::ST_OT_BIT])
      else $error("over-temperature flag lost without a clear");

   irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_03
      irq == |(status & irq_en))
      else $error("interrupt level does not follow enabled status");

   alarm_release_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_01
      rpm >= thresh && !(sense_s.overtemp && ctrl.ot_alarm_en) |=> alarm_b && !alarm_oe)
      else $error("alarm held without a fault");

   alarm_drive_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_01
      alarm_oe == !alarm_b)
      else $error("alarm enable disagrees with alarm level");

   shut_enter_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_14
      ctrl.shutdown_request |=> state == fpf_pkg::ST_SHUT)
      else $error("shutdown request not obeyed");

   restart_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_09
      state == fpf_pkg::ST_SHUT && !ctrl.shutdown_request |=> state == fpf_pkg::ST_START)
      else $error("no startup after leaving shutdown");

   run_floor_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_06
      $past(state) == fpf_pkg::ST_RUN && $past(slot_cnt) < fpf_pkg::DUTY_BASE && $past(rst_b)
         |-> pwm_drive)
      else $error("drive low inside the minimum high time");

endmodule // fpf_core

/* File: hw/fpf_pkg.sv */
// constants, types and register map of the fan pwm startup and fault core
package fpf_pkg;

   localparam int CLK_HZ          = 200_000_000;
   localparam int STARTUP_TIME_MS = 1000;
   localparam int STARTUP_CYC     = CLK_HZ / 1000 * STARTUP_TIME_MS;
   localparam int MEAS_TIME_MS    = 1000;
   localparam int MEAS_CYC        = CLK_HZ / 1000 * MEAS_TIME_MS;
   localparam int PWM_HZ_NOM      = 30;
   localparam int PWM_HZ_MIN      = 15;
   localparam int PWM_HZ_MAX      = 35;
   localparam int PWM_SLOTS       = 300;
   localparam int RPM_PER_PPS     = 30;

   localparam logic [8:0]  SLOT_LAST    = 9'h12b;
   localparam logic [8:0]  DUTY_BASE    = 9'h05a;
   localparam logic [8:0]  DUTY_STEP    = 9'h00e;
   localparam logic [3:0]  DUTY_OPEN    = 4'h2;
   localparam logic [3:0]  DUTY_FULL    = 4'hf;
   localparam logic [3:0]  DUTY_RESET   = 4'h0;
   localparam logic [15:0] THRESH_RESET = 16'h01f4;

   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_DUTY    = 8'h04;
   localparam logic [7:0] OFS_THRESH  = 8'h08;
   localparam logic [7:0] OFS_RPM     = 8'h0c;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h18;

   localparam int CTRL_SHUTDOWN_BIT = 0;
   localparam int CTRL_OT_ALARM_BIT = 1;
   localparam int CTRL_DUTY_SRC_BIT = 5;
   localparam int ST_FAN_BIT        = 0;
   localparam int ST_OT_BIT         = 5;
   localparam int ST_W              = 6;

   typedef struct packed {
      logic       tach;
      logic       overtemp;
      logic       vin_open;
      logic [3:0] temp_code;
   } fpf_sense_t;

   typedef struct packed {
      logic shutdown_request;
      logic ot_alarm_en;
      logic duty_source_select;
   } fpf_ctrl_t;

   typedef enum logic [1:0] {
      ST_START = 2'b00,
      ST_RUN   = 2'b01,
      ST_SHUT  = 2'b10
   } fpf_state_t;

endpackage

/* File: hw/fpf_tach.sv */
// tachometer pulse counter and rpm calculation
`timescale 1ns/100ps
module fpf_tach #(
   parameter int MEAS_CYC = fpf_pkg::MEAS_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        tach_s,
   output logic [15:0]      rpm
);

   localparam logic [27:0] WIN_LAST = 28'(MEAS_CYC - 1);

   logic        tach_d;
   logic [27:0] win_cnt;
   logic [15:0] pulse_cnt;
   logic        next_tach_d;
   logic [27:0] next_win_cnt;
   logic [15:0] next_pulse_cnt;
   logic [15:0] next_rpm;
   logic        rise;

   always_comb begin
      rise           = tach_s & ~tach_d;
      next_tach_d    = tach_s;
      next_win_cnt   = win_cnt + 28'h0000001;
      next_pulse_cnt = pulse_cnt + {15'h0000, rise};
      next_rpm       = rpm;
      if (win_cnt == WIN_LAST) begin
         next_win_cnt   = 28'h0000000;
         next_pulse_cnt = {15'h0000, rise};
         next_rpm       = 16'(pulse_cnt * 16'(fpf_pkg::RPM_PER_PPS)); // RULE_02
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tach_d    <= 1'b0;
         win_cnt   <= 28'h0000000;
         pulse_cnt <= 16'h0000;
         rpm       <= 16'h0000;
      end else begin
         tach_d    <= next_tach_d;
         win_cnt   <= next_win_cnt;
         pulse_cnt <= next_pulse_cnt;
         rpm       <= next_rpm;
      end
   end

   rpm_update_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_02
      win_cnt == WIN_LAST |=> rpm == 16'($past(pulse_cnt) * 16'(fpf_pkg::RPM_PER_PPS)))
      else $error("rpm not taken from pulse count at window end");

endmodule // fpf_tach
